// file: hw/dgpio_top.sv
// Purpose: Two groups of three 8-bit ports, cascadable counter clocking,
//          two-channel edge interrupt with one request line.
// Assumes: Registers reached by byte offset, read data one cycle later.
// Notes:   Counter internals live outside; block gives clocks and gates.
`timescale 1ns/100ps
`include "dgpio_consts.svh"
module dgpio_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_ce,
  input  wire logic                  i_power_on,
  input  wire logic                  i_retention_strap,
  input  wire logic [11:0]           i_force_out_strap,
  input  wire logic [`DGPIO_AW-1:0]  i_addr,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [7:0]            i_wdata,
  output logic      [7:0]            o_rdata,
  input  wire logic [47:0]           i_pin,
  output logic      [47:0]           o_pin,
  output logic      [47:0]           o_pin_oe,
  input  wire logic                  i_counter0_clock_strap,
  input  wire logic                  i_counter1_clock_strap,
  input  wire logic                  i_counter2_clock_strap,
  input  wire logic                  i_counter0_ext_clock_pin,
  input  wire logic                  i_counter1_ext_clock_pin,
  input  wire logic                  i_counter2_ext_clock_pin,
  input  wire logic [2:0]            i_cnt_out,
  input  wire logic                  i_gate_en,
  input  wire logic                  i_counter0_gate_pin,
  input  wire logic                  i_counter1_gate_pin,
  input  wire logic                  i_counter2_gate_pin,
  output logic      [2:0]            o_cnt_clk,
  output logic      [2:0]            o_cnt_gate,
  output logic                       o_irq
);
  // Segment order per group: C low, B, C high, A (8 segments in all)
  logic [7:0]  dir_in_q;
  logic [47:0] latch_q;
  logic [7:0]  icr_q;
  logic [5:0]  raw_q;
  logic        tick_q;
  logic [47:0] pin_q;
  logic [47:0] oe_q;

  // Retention only survives a hot reset; power-on clears everything
  wire         keep_w   = i_retention_strap & ~i_power_on;

  function automatic logic [5:0] seg_addr(input logic [3:0] s);
    logic [5:0] base;
    base = s[2] ? `DGPIO_OFF_PA1 : `DGPIO_OFF_PA0;
    unique case (s[1:0])
      2'h0: seg_addr = base + `DGPIO_OFF_PC0;
      2'h1: seg_addr = base + `DGPIO_OFF_PB0;
      2'h2: seg_addr = base + `DGPIO_OFF_PC0;
      2'h3: seg_addr = base;
    endcase
  endfunction

  function automatic logic [2:0] dir_bit(input logic [1:0] k);
    unique case (k)
      2'h0: dir_bit = 3'(`DGPIO_DIR_CLO);
      2'h1: dir_bit = 3'(`DGPIO_DIR_B);
      2'h2: dir_bit = 3'(`DGPIO_DIR_CHI);
      default: dir_bit = 3'(`DGPIO_DIR_A);
    endcase
  endfunction

  wire wr_dir0 = i_ce & i_wr & (i_addr == `DGPIO_OFF_DIR0);
  wire wr_dir1 = i_ce & i_wr & (i_addr == `DGPIO_OFF_DIR1);
  wire wr_icr  = i_ce & i_wr & (i_addr == `DGPIO_OFF_ICR);

  // Per-segment direction and latch, one generate per segment (4 bits for C halves, 8 for A and B)
  logic [47:0] drive_w;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_seg
      localparam logic [3:0] S    = 4'(g);
      localparam int         K    = g % 4;
      localparam int         W    = (K == 1 || K == 3) ? 8 : 4;
      localparam int         LO   = (K == 0) ? 0 : (K == 1) ? 8 :
                                    (K == 2) ? 4 : 16;
      localparam int         BASE = (g / 4) * 24;
      logic         dir_q;
      logic [W-1:0] lat_q;
      wire          wr_dir = (g < 4) ? wr_dir0 : wr_dir1;
      wire          forced = i_force_out_strap[g];
      wire          wr_dat = i_ce & i_wr & (i_addr == seg_addr(S));
      // C high takes the upper nibble, whole ports the full byte
      wire [W-1:0]  wval   = (K == 2) ? W'(i_wdata[7:4]) : W'(i_wdata);
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          if (!keep_w) begin
            dir_q <= ~forced;
            lat_q <= '0;
          end
        end else begin
          if (forced && i_ce)
            dir_q <= 1'b0;
          else if (wr_dir)
            dir_q <= i_wdata[dir_bit(S[1:0])];
          if (wr_dat)
            lat_q <= wval;
        end
      end
      assign dir_in_q[g]           = dir_q;
      assign latch_q[BASE+LO +: W] = lat_q;
      assign drive_w[BASE+LO +: W] = {W{dir_q}};
    end
  endgenerate

  // Map 48 bits to pins: group order C,B,A from bit 0, each 8 bits
  wire [47:0] pin_oe_d = ~drive_w;
  wire [47:0] pin_val_d = latch_q & pin_oe_d;

  always_ff @(posedge i_clk) begin
    if (i_ce || !i_rstn) begin
      pin_q <= pin_val_d | (~pin_oe_d & {48{1'b0}});
      oe_q  <= pin_oe_d;
    end
  end
  assign o_pin    = pin_q;
  assign o_pin_oe = oe_q;

  // Readback: outputs return driven value, inputs the pin level
  wire [47:0] port_rd = (pin_oe_d & latch_q) | (~pin_oe_d & i_pin);
  // Layout per group at 24*grp: C lo 0, C hi 4, B 8..15, A 16..23
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    unique case (i_addr)
      `DGPIO_OFF_PA0: rd_d = port_rd[23:16];
      `DGPIO_OFF_PB0: rd_d = port_rd[15:8];
      `DGPIO_OFF_PC0: rd_d = port_rd[7:0];
      `DGPIO_OFF_PA1: rd_d = port_rd[47:40];
      `DGPIO_OFF_PB1: rd_d = port_rd[39:32];
      `DGPIO_OFF_PC1: rd_d = port_rd[31:24];
      `DGPIO_OFF_ICR: rd_d = icr_q;
      default: rd_d = 8'h00;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (i_ce && i_rd)
      o_rdata <= rd_d;
  end

  // Internal 10 MHz tick: clock enable at half the system rate
  always_ff @(posedge i_clk) begin
    if (!i_rstn)
      tick_q <= 1'b0;
    else if (i_ce)
      tick_q <= ~tick_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_cnt_clk  <= 3'h0;
      o_cnt_gate <= 3'h0;
    end else if (i_ce) begin
      o_cnt_clk[0] <= i_counter0_clock_strap ? tick_q
                      : i_counter0_ext_clock_pin;
      o_cnt_clk[1] <= i_counter1_clock_strap ? i_cnt_out[0]
                      : i_counter1_ext_clock_pin;
      o_cnt_clk[2] <= i_counter2_clock_strap ? tick_q
                      : i_counter2_ext_clock_pin;
      // Floating gate pins read high through the pull-up
      o_cnt_gate <= i_gate_en ? {i_counter2_gate_pin,
                    i_counter1_gate_pin, i_counter0_gate_pin}
                    : 3'h7;
    end
  end

  // Interrupt sources, pins C line 0 and line 4 or a counter output per group
  function automatic logic src_sel(input logic [1:0] m, input logic l0,
                                   input logic l4, input logic cnt);
    unique case (dgpio_pkg::dgpio_src_t'(m))
      dgpio_pkg::DGPIO_SRC_OFF:  src_sel = 1'b0;
      dgpio_pkg::DGPIO_SRC_L0:   src_sel = l0;
      dgpio_pkg::DGPIO_SRC_L0L4: src_sel = l0 & l4;
      dgpio_pkg::DGPIO_SRC_CNT:  src_sel = cnt;
    endcase
  endfunction
  wire s0 = src_sel(icr_q[1:0], port_rd[0], port_rd[4], i_cnt_out[1]);
  wire s1 = src_sel(icr_q[5:4], port_rd[24], port_rd[28],
                    i_cnt_out[2]);
  // Old source rebuilt from old line levels under the current mode,
  // so a mode write on its own never looks like an edge
  wire p0 = src_sel(icr_q[1:0], raw_q[0], raw_q[1], raw_q[2]);
  wire p1 = src_sel(icr_q[5:4], raw_q[3], raw_q[4], raw_q[5]);
  wire e0 = (icr_q[1:0] != 2'h0) &
            (icr_q[2] ? (s0 & ~p0) : (~s0 & p0));
  wire e1 = (icr_q[5:4] != 2'h0) &
            (icr_q[6] ? (s1 & ~p1) : (~s1 & p1));

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      icr_q <= `DGPIO_ICR_RST;
      raw_q <= '1;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      raw_q <= {i_cnt_out[2], port_rd[28], port_rd[24],
                i_cnt_out[1], port_rd[4], port_rd[0]};
      if (wr_icr) begin
        icr_q[2:0] <= i_wdata[2:0];
        icr_q[6:4] <= i_wdata[6:4];
      end
      // Set wins over a same-cycle clear
      icr_q[`DGPIO_ICR_FLAG0] <= e0 | (icr_q[`DGPIO_ICR_FLAG0] &
        ~(wr_icr & i_wdata[`DGPIO_ICR_FLAG0]));
      icr_q[`DGPIO_ICR_FLAG1] <= e1 | (icr_q[`DGPIO_ICR_FLAG1] &
        ~(wr_icr & i_wdata[`DGPIO_ICR_FLAG1]));
      o_irq <= (e0 | (icr_q[3] & ~(wr_icr & i_wdata[3]))) |
               (e1 | (icr_q[7] & ~(wr_icr & i_wdata[7])));
    end
  end

  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && e0 |=> icr_q[3]) else $error("flag0 not set");
  irq_on_edge_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && e1 |=> o_irq) else $error("irq not raised");
  irq_flag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_irq == (icr_q[3] | icr_q[7])) else $error("irq mismatch");
  flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && wr_icr && i_wdata[7] && !e1 |=> !icr_q[7])
    else $error("flag1 not cleared");
  forced_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && i_force_out_strap[7] |=> !dir_in_q[7])
    else $error("forced port is input");
  mode_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    icr_q[1:0] == 2'h0 |-> !e0) else $error("mode off edge");
  tick_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce |=> tick_q != $past(tick_q)) else $error("tick stuck");
  gate_pullup_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && !i_gate_en |=> o_cnt_gate == 3'h7)
    else $error("gate not pulled up");
  port_b_dir_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_dir0 && !i_force_out_strap[1] |=> dir_in_q[1] == $past(i_wdata[1]))
    else $error("port B dir");
  cv_irq_c: cover property (@(posedge i_clk) o_irq);
  cv_both_c: cover property (@(posedge i_clk) icr_q[3] && icr_q[7]);
  cv_clr_c: cover property (@(posedge i_clk) o_irq ##1 !o_irq);
  cv_out_c: cover property (@(posedge i_clk) o_pin_oe[23:16] == 8'hff);
  cv_gate_c: cover property (@(posedge i_clk) o_cnt_gate != 3'h7);
endmodule

// file: hw/dgpio_consts.svh
// Purpose: Offsets, field positions and timing constants for the dual
//          group parallel I/O block.
// Assumes: Register offsets are byte offsets from the block base.
// Notes:   Definitions only.
`ifndef DGPIO_CONSTS_SVH
`define DGPIO_CONSTS_SVH

`define DGPIO_AW            6
`define DGPIO_OFF_DIR0      6'h03
`define DGPIO_OFF_DIR1      6'h07
`define DGPIO_OFF_ICR       6'h20
`define DGPIO_OFF_PA0       6'h00
`define DGPIO_OFF_PB0       6'h01
`define DGPIO_OFF_PC0       6'h02
`define DGPIO_OFF_PA1       6'h04
`define DGPIO_OFF_PB1       6'h05
`define DGPIO_OFF_PC1       6'h06
`define DGPIO_DIR_CLO       0
`define DGPIO_DIR_B         1
`define DGPIO_DIR_CHI       3
`define DGPIO_DIR_A         4
`define DGPIO_ICR_FLAG0     3
`define DGPIO_ICR_FLAG1     7
`define DGPIO_ICR_RST       8'h00
`define DGPIO_PORT_IN_RST   8'hff
`define DGPIO_PORT_OUT_RST  8'h00
`define DGPIO_CLK_HZ        20000000
`define DGPIO_TICK_HZ       10000000
`define DGPIO_TICK_DIV      (`DGPIO_CLK_HZ / `DGPIO_TICK_HZ)

`endif

// file: hw/dgpio_pkg.sv
// Purpose: Types for the dual group parallel I/O block.
// Assumes: Used with dgpio_consts.svh.
// Notes:   Nothing here is imported; use dgpio_pkg::name.
package dgpio_pkg;
  typedef enum logic [1:0] {
    DGPIO_SRC_OFF   = 2'h0,
    DGPIO_SRC_L0    = 2'h1,
    DGPIO_SRC_L0L4  = 2'h2,
    DGPIO_SRC_CNT   = 2'h3
  } dgpio_src_t;
endpackage

// file: verif/dgpio_field.sv
// Purpose: Field devices wired to the 48 connector pins.
// Assumes: Lines that nobody drives sit on pull-ups (value in i_field).
// Notes:   Where the block drives a pin, the wire follows the block.
`timescale 1ns/100ps
module dgpio_field (
  input  wire logic [47:0] i_pin_drv,
  input  wire logic [47:0] i_pin_oe,
  input  wire logic [47:0] i_field,
  output logic      [47:0] o_wire
);
  // Block wins where it drives; field or pull-up elsewhere
  assign o_wire = (i_pin_oe & i_pin_drv) | (~i_pin_oe & i_field);
endmodule

// file: verif/dgpio_top_test.sv
// Purpose: Self-checking bench for the dual group parallel I/O block.
// Assumes: Group 1 port A strapped as output; other segments software set.
// Notes:   External counter clock pins stay tied low here.
`timescale 1ns/100ps
`include "dgpio_consts.svh"
module dgpio_top_test;
  logic        clk, rstn, ce, pwr, ret, rd, wr;
  logic [11:0] force_out;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [47:0] pin_in, pin_out, pin_oe, field;
  logic [2:0]  cnt_out, cnt_clk, cnt_gate, strap;
  logic        irq, gate_en, tck;
  logic [2:0]  gpin;
  int          error_cnt, checked, cycles;

  dgpio_top uut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_power_on(pwr),
    .i_retention_strap(ret), .i_force_out_strap(force_out), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
    .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe),
    .i_counter0_clock_strap(strap[0]), .i_counter1_clock_strap(strap[1]),
    .i_counter2_clock_strap(strap[2]), .i_counter0_ext_clock_pin(1'b0),
    .i_counter1_ext_clock_pin(1'b0), .i_counter2_ext_clock_pin(1'b0),
    .i_cnt_out(cnt_out), .i_gate_en(gate_en), .i_counter0_gate_pin(gpin[0]),
    .i_counter1_gate_pin(gpin[1]), .i_counter2_gate_pin(gpin[2]),
    .o_cnt_clk(cnt_clk), .o_cnt_gate(cnt_gate), .o_irq(irq));

  dgpio_field field_u (.i_pin_drv(pin_out), .i_pin_oe(pin_oe),
    .i_field(field), .o_wire(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] exp, got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(2);
  endtask

  // Read data stands until the next read, so one spare edge is safe
  task automatic rd_chk(input string nm, input logic [5:0] a,
                        input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
    chk(nm, {40'h0, exp}, {40'h0, rdata});
  endtask

  task automatic do_reset(input logic r, p);
    ret = r;
    pwr = p;
    rstn = 1'b0;
    step(3);
    rstn = 1'b1;
    pwr = 1'b0;
    step(1);
  endtask

  task automatic pulse_field(input int b);
    field[b] = 1'b0;
    step(3);
    field[b] = 1'b1;
    step(3);
  endtask

  initial begin
    rstn = 1'b0; ce = 1'b1; pwr = 1'b1; ret = 1'b0; rd = 1'b0; wr = 1'b0;
    addr = 6'h00; wdata = 8'h00; force_out = 12'h080; strap = 3'h7;
    field = {48{1'b1}}; cnt_out = 3'h0; error_cnt = 0; checked = 0;
    cycles = 0; gate_en = 1'b1; gpin = 3'h7; tck = 1'b0;
    do_reset(1'b0, 1'b1);
    chk("oe after reset", 48'hff00_0000_0000, pin_oe);
    chk("forced low", 48'h0, pin_out & 48'hff00_0000_0000);
    rd_chk("port a0 input", `DGPIO_OFF_PA0, 8'hff);
    rd_chk("icr reset", `DGPIO_OFF_ICR, 8'h00);
    // Group 1 line 0, rising edge; a falling edge alone must not fire
    wr_reg(`DGPIO_OFF_ICR, 8'h50);
    field[24] = 1'b0;
    step(3);
    chk("no irq on fall", 48'h0, {47'h0, irq});
    field[24] = 1'b1;
    step(3);
    chk("irq on rise", 48'h1, {47'h0, irq});
    rd_chk("icr flag1", `DGPIO_OFF_ICR, 8'hd0);
    // Group 0 counter source, falling edge; both pend on one line
    wr_reg(`DGPIO_OFF_ICR, 8'h53);
    cnt_out[1] = 1'b1;
    step(3);
    cnt_out[1] = 1'b0;
    step(3);
    rd_chk("icr both", `DGPIO_OFF_ICR, 8'hdb);
    wr_reg(`DGPIO_OFF_ICR, 8'hd3);
    rd_chk("icr flag0 left", `DGPIO_OFF_ICR, 8'h5b);
    chk("irq still", 48'h1, {47'h0, irq});
    wr_reg(`DGPIO_OFF_ICR, 8'h5b);
    chk("irq cleared", 48'h0, {47'h0, irq});
    // Lines 0 and 4 combined: edge only when line 4 joins
    field[28] = 1'b0;
    wr_reg(`DGPIO_OFF_ICR, 8'h60);
    field[28] = 1'b1;
    step(3);
    chk("irq lines 0 4", 48'h1, {47'h0, irq});
    wr_reg(`DGPIO_OFF_ICR, 8'he0);
    wr_reg(`DGPIO_OFF_ICR, 8'h00);
    pulse_field(24);
    chk("irq disabled", 48'h0, {47'h0, irq});
    // Latch loaded before the port turns to output
    wr_reg(`DGPIO_OFF_PA0, 8'h5a);
    wr_reg(`DGPIO_OFF_DIR0, 8'he4);
    chk("oe group0 out", 48'hff00_00ff_ffff, pin_oe);
    chk("pa0 driven", 48'h5a, {40'h0, pin_out[23:16]});
    rd_chk("pa0 readback", `DGPIO_OFF_PA0, 8'h5a);
    wr_reg(`DGPIO_OFF_DIR1, 8'hff);
    chk("forced kept", 48'hff00_00ff_ffff, pin_oe);
    wr_reg(`DGPIO_OFF_DIR0, 8'h1b);
    chk("group0 input", 48'hff00_0000_0000, pin_oe);
    wr_reg(`DGPIO_OFF_DIR0, 8'h02);
    chk("only b input", 48'hff00_00ff_00ff, pin_oe);
    do_reset(1'b1, 1'b0);
    chk("hot oe kept", 48'hff00_00ff_00ff, pin_oe);
    chk("hot latch kept", 48'h5a, {40'h0, pin_out[23:16]});
    do_reset(1'b1, 1'b1);
    chk("power on oe", 48'hff00_0000_0000, pin_oe);
    gpin = 3'h5;
    step(2);
    chk("gate pins", 48'h5, {45'h0, cnt_gate});
    gate_en = 1'b0;
    step(2);
    chk("gate pulled up", 48'h7, {45'h0, cnt_gate});
    cnt_out[0] = 1'b1;
    step(2);
    chk("cascade clock", 48'h1, {47'h0, cnt_clk[1]});
    tck = cnt_clk[2];
    step(1);
    chk("tick toggles", {47'h0, ~tck}, {47'h0, cnt_clk[2]});
    close_out();
  end
endmodule
